/* File: trfob_pkg.sv */
/*
 * Shared constants and carrier types for the remote-channel result filter,
 * offset and beta-result block.
 * Assumes a byte-wide register port from the serial interface front end.
 */
package trfob_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_OFFSET_CODE = 8'h16;
    localparam logic [7:0] ADDR_OFFSET_EN = 8'h17;
    localparam logic [7:0] ADDR_AVG_EN = 8'h18;
    localparam logic [7:0] ADDR_BETA_EN = 8'h19;
    localparam logic [7:0] ADDR_BETA_CH1 = 8'h1a;
    localparam logic [7:0] ADDR_BETA_CH2 = 8'h1b;
    localparam logic [7:0] ADDR_BETA_CH3 = 8'h1c;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and field layout
    localparam logic [7:0] RST_OFFSET_CODE = 8'h77;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [3:0] RST_BETA_CODE = 4'h0;
    localparam logic [7:0] CHAN_EN_MASK = 8'h0e;
    localparam int CHAN_FIRST = 1;
    localparam int CHAN_LAST = 3;
    localparam logic [3:0] BETA_FAULT_CODE = 4'hf;
    localparam logic [15:0] FAULT_TEMP = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Offset arithmetic: code in 1/8 degree, temperature in 1/256 degree
    localparam logic signed [15:0] OFFSET_BIAS = 16'sh0077;
    localparam int OFFSET_SHIFT = 5;
    localparam logic [2:0] HIST_DEPTH = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [15:0] raw;
    } trfob_conv_t;

    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [3:0] code;
        logic low;
    } trfob_beta_t;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } trfob_reg_t;

endpackage

/* File: trfob_core.sv */
/*
 * Result post-processing for the three remote channels: averaging filter,
 * programmable offset, beta-compensation enables and beta result codes.
 * Assumes conversion and beta-measurement results arrive as one-cycle
 * pulses in the core_clk domain, and a register front end that issues
 * single-cycle read and write strobes.
 */
// Function
// RULE1: filtered result is mean of last four
// RULE2: one-shot results averaged like continuous ones
// RULE3: enabling filter keeps held value unchanged
// RULE4: filter enables in bits 3:1, rest zero
// RULE5: beta enables in bits 3:1, reset zero
// RULE6: beta code 4 bits, F means fault
// RULE7: offset is code/8 minus 14.875 degrees
// RULE8: offset code resets to 77h
// RULE9: offset enables per channel in bits 3:1
// RULE10: highest-temperature path sees un-offset results
// RULE11: low beta skips channel, faults, loads zero
// RULE12: beta enable changes affect later conversions only
// RULE13: four-deep history, partial average until full
`timescale 1ns/1ns
module trfob_core #(
    parameter int TEMP_W = 16
) (
    // Clock, reset and enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire trfob_pkg::trfob_reg_t regReq,
    output logic [7:0] regRdData,
    // Conversion events
    input wire logic [3:1] convStart,
    input wire trfob_pkg::trfob_conv_t conv,
    input wire trfob_pkg::trfob_beta_t beta,
    // Results
    output logic [3:1][TEMP_W-1:0] tempOut,
    output logic [3:1][TEMP_W-1:0] highCmpTemp,
    output logic [3:1] diodeFault,
    output logic [3:1] betaCompActive
);

    ////////////////////////////////////////////////////////////////////////
    // Register read decode, used only by the read data register
    function automatic logic [7:0] readMux(
        input logic [7:0] a,
        input logic [7:0] offCode,
        input logic [7:0] offEn,
        input logic [7:0] avgEn,
        input logic [7:0] betaEn,
        input logic [3:1][3:0] codes
    );
        case (a)
            trfob_pkg::ADDR_OFFSET_CODE: readMux = offCode;
            trfob_pkg::ADDR_OFFSET_EN: readMux = offEn;
            trfob_pkg::ADDR_AVG_EN: readMux = avgEn;
            trfob_pkg::ADDR_BETA_EN: readMux = betaEn;
            trfob_pkg::ADDR_BETA_CH1: readMux = {4'h0, codes[1]};
            trfob_pkg::ADDR_BETA_CH2: readMux = {4'h0, codes[2]};
            trfob_pkg::ADDR_BETA_CH3: readMux = {4'h0, codes[3]};
            default: readMux = 8'h00;
        endcase
    endfunction

    // Average of the filled part of the history
    // Halves and quarters are arithmetic shifts and floor; thirds divide
    // and truncate toward zero, so negative means round differently
    function automatic logic [TEMP_W-1:0] avgOf(
        input logic signed [TEMP_W+1:0] s,
        input logic [2:0] n
    );
        case (n)
            3'h2: avgOf = TEMP_W'(s >>> 1);
            3'h3: avgOf = TEMP_W'(s / 3);
            3'h4: avgOf = TEMP_W'(s >>> 2);
            default: avgOf = TEMP_W'(s);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [7:0] offsetCode, next_offsetCode;
    logic [7:0] offsetEn, next_offsetEn;
    logic [7:0] avgEn, next_avgEn;
    logic [7:0] betaEn, next_betaEn;
    logic [7:0] next_regRdData;
    logic [3:1][3:0] betaCode, next_betaCode;

    // Software writes; reserved bits forced to zero
    always_comb begin
        next_offsetCode = offsetCode;
        next_offsetEn = offsetEn;
        next_avgEn = avgEn;
        next_betaEn = betaEn;
        if (regReq.wrEn) begin
            case (regReq.addr)
                trfob_pkg::ADDR_OFFSET_CODE: next_offsetCode = regReq.wrData; // RULE7
                trfob_pkg::ADDR_OFFSET_EN: next_offsetEn = regReq.wrData & trfob_pkg::CHAN_EN_MASK; // RULE9
                trfob_pkg::ADDR_AVG_EN: next_avgEn = regReq.wrData & trfob_pkg::CHAN_EN_MASK; // RULE4
                trfob_pkg::ADDR_BETA_EN: next_betaEn = regReq.wrData & trfob_pkg::CHAN_EN_MASK; // RULE5
                default: next_offsetCode = offsetCode;
            endcase
        end
        next_regRdData = regReq.rdEn
            ? readMux(regReq.addr, offsetCode, offsetEn, avgEn, betaEn, betaCode)
            : regRdData;
    end

    // Register the configuration; beta codes live with channel state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            offsetCode <= trfob_pkg::RST_OFFSET_CODE; // RULE8
            offsetEn <= trfob_pkg::RST_ENABLES;
            avgEn <= trfob_pkg::RST_ENABLES;
            betaEn <= trfob_pkg::RST_ENABLES;
            regRdData <= 8'h00;
        end else if (ce) begin
            offsetCode <= next_offsetCode;
            offsetEn <= next_offsetEn;
            avgEn <= next_avgEn;
            betaEn <= next_betaEn;
            regRdData <= next_regRdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel history, held raw result and beta state
    logic [3:1][3:0][TEMP_W-1:0] hist, next_hist;
    logic [3:1][2:0] fill, next_fill;
    logic [3:1][TEMP_W-1:0] rawHeld, next_rawHeld;
    logic [3:1] avgPrev;
    logic [3:1] next_fault, next_betaActive;
    logic [3:1][TEMP_W-1:0] next_tempOut;
    logic signed [TEMP_W-1:0] offsetVal;

    // Applied offset in 1/256 degree units; code 77h gives zero
    assign offsetVal = TEMP_W'(($signed({8'h00, offsetCode}) - trfob_pkg::OFFSET_BIAS)
                        <<< trfob_pkg::OFFSET_SHIFT); // RULE7

    // Channel update; the conversion path never looks at the one-shot bit
    always_comb begin
        logic signed [TEMP_W+1:0] sum;
        logic [3:0][TEMP_W-1:0] h;
        logic [2:0] f;
        sum = '0;
        h = '0;
        f = 3'h0;
        next_hist = hist;
        next_fill = fill;
        next_rawHeld = rawHeld;
        next_betaCode = betaCode;
        next_fault = 3'b000;
        next_betaActive = betaCompActive;
        for (int c = trfob_pkg::CHAN_FIRST; c <= trfob_pkg::CHAN_LAST; c++) begin
            h = hist[c];
            f = fill[c];
            // Fresh start on enable; held value untouched
            if (avgEn[c] && !avgPrev[c]) begin
                h = '0; // RULE3
                f = 3'h0; // RULE13
            end
            // Snapshot at conversion start only
            if (convStart[c]) begin
                next_betaActive[c] = betaEn[c]; // RULE12
            end
            if (beta.valid && beta.chan == 2'(c)) begin
                if (beta.low && betaCompActive[c]) begin
                    next_betaCode[c] = trfob_pkg::BETA_FAULT_CODE; // RULE6
                    next_rawHeld[c] = trfob_pkg::FAULT_TEMP; // RULE11
                    next_fault[c] = 1'b1; // RULE11
                end else begin
                    next_betaCode[c] = beta.code; // RULE6
                end
            end
            if (conv.valid && conv.chan == 2'(c)) begin
                if (avgEn[c]) begin
                    h = {h[2:0], conv.raw}; // RULE2
                    if (f != trfob_pkg::HIST_DEPTH) begin
                        f = f + 3'h1; // RULE13
                    end
                    sum = 18'($signed(h[0])) + 18'($signed(h[1]))
                        + 18'($signed(h[2])) + 18'($signed(h[3]));
                    next_rawHeld[c] = avgOf(sum, f); // RULE1
                end else begin
                    next_rawHeld[c] = conv.raw;
                end
            end
            next_hist[c] = h;
            next_fill[c] = f;
            // Offset only on the reported path
            next_tempOut[c] = offsetEn[c] ? TEMP_W'(rawHeld[c] + offsetVal) : rawHeld[c]; // RULE9
        end
    end

    // Register channel state; outputs lag the held raw value by a cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hist <= '0;
            fill <= '0;
            rawHeld <= '0;
            betaCode <= {3{trfob_pkg::RST_BETA_CODE}};
            avgPrev <= 3'b000;
            diodeFault <= 3'b000;
            betaCompActive <= 3'b000;
            tempOut <= '0;
            highCmpTemp <= '0;
        end else if (ce) begin
            hist <= next_hist;
            fill <= next_fill;
            rawHeld <= next_rawHeld;
            betaCode <= next_betaCode;
            avgPrev <= avgEn[3:1];
            diodeFault <= next_fault;
            betaCompActive <= next_betaActive;
            tempOut <= next_tempOut;
            highCmpTemp <= rawHeld; // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_enableRise;
        ce && avgEn[1] && !avgPrev[1];
    endsequence

    sequence s_lowBeta;
        ce && beta.valid && beta.chan == 2'h3 && beta.low && betaCompActive[3]
            && !(conv.valid && conv.chan == 2'h3);
    endsequence

    property p_holdOnEnable;
        s_enableRise ##0 (!conv.valid && !beta.valid) |=> $stable(rawHeld[1]);
    endproperty
    a_holdOnEnable: assert property (p_holdOnEnable) else $error("held value moved on enable"); // RULE3

    property p_fillRestart;
        s_enableRise ##0 !conv.valid |=> fill[1] == 3'h0;
    endproperty
    a_fillRestart: assert property (p_fillRestart) else $error("history not restarted"); // RULE13

    property p_firstSample;
        ce && avgEn[1] && avgPrev[1] && fill[1] == 3'h0 && conv.valid && conv.chan == 2'h1
            |=> rawHeld[1] == $past(conv.raw);
    endproperty
    a_firstSample: assert property (p_firstSample) else $error("single sample not passed"); // RULE1

    property p_fillCap;
        fill[1] <= trfob_pkg::HIST_DEPTH && fill[2] <= trfob_pkg::HIST_DEPTH;
    endproperty
    a_fillCap: assert property (p_fillCap) else $error("history count overflow"); // RULE13

    property p_offsetReset;
        @(posedge core_clk) disable iff (1'b0) !rst_n |=> offsetCode == 8'h77;
    endproperty
    a_offsetReset: assert property (p_offsetReset) else $error("offset reset wrong"); // RULE8

    property p_reservedZero;
        (avgEn & ~trfob_pkg::CHAN_EN_MASK) == 8'h00 && (betaEn & ~trfob_pkg::CHAN_EN_MASK) == 8'h00;
    endproperty
    a_reservedZero: assert property (p_reservedZero) else $error("reserved bit set"); // RULE4

    property p_betaReadHigh;
        ce && regReq.rdEn && regReq.addr == trfob_pkg::ADDR_BETA_CH1 |=> regRdData[7:4] == 4'h0;
    endproperty
    a_betaReadHigh: assert property (p_betaReadHigh) else $error("beta upper bits set"); // RULE6

    property p_lowBetaFault;
        s_lowBeta |=> diodeFault[3] && rawHeld[3] == trfob_pkg::FAULT_TEMP
            && betaCode[3] == 4'hf;
    endproperty
    a_lowBetaFault: assert property (p_lowBetaFault) else $error("low beta not faulted"); // RULE11

    // Reported value of a faulted channel is zero plus any offset
    property p_lowBetaZero;
        s_lowBeta ##1 ce
            |=> tempOut[3] == ($past(offsetEn[3]) ? $past(offsetVal) : trfob_pkg::FAULT_TEMP);
    endproperty
    a_lowBetaZero: assert property (p_lowBetaZero) else $error("faulted result not zero"); // RULE11

    property p_betaSnapshot;
        ce && convStart == 3'b000 |=> $stable(betaCompActive);
    endproperty
    a_betaSnapshot: assert property (p_betaSnapshot) else $error("beta enable leaked"); // RULE12

    property p_offsetApplied;
        ce && offsetEn[1] ##1 ce && $stable(offsetCode)
            |-> tempOut[1] == TEMP_W'($past(rawHeld[1])
                + ((TEMP_W'(offsetCode) - TEMP_W'(trfob_pkg::RST_OFFSET_CODE))
                << trfob_pkg::OFFSET_SHIFT));
    endproperty
    a_offsetApplied: assert property (p_offsetApplied) else $error("offset not applied"); // RULE7

    property p_highUnoffset;
        ce |=> highCmpTemp[2] == $past(rawHeld[2]);
    endproperty
    a_highUnoffset: assert property (p_highUnoffset) else $error("compare path offset"); // RULE10

    // Enable low must freeze held results and configuration alike
    property p_ceFreeze;
        !ce |=> $stable(rawHeld) && $stable(tempOut) && $stable(offsetCode);
    endproperty
    a_ceFreeze: assert property (p_ceFreeze) else $error("state moved with enable low");

endmodule

/* File: trfob_host_model.sv */
/*
 * Register host model: issues single-cycle write and read strobes on the
 * block's register port, the way the serial front end would.
 * Assumes requests launch at the falling edge of core_clk and that read
 * data is valid one cycle after the read strobe is taken.
 */
`timescale 1ns/1ns
module trfob_host_model (
    // Clock
    input wire logic core_clk,
    // Register port
    output trfob_pkg::trfob_reg_t regReq,
    input wire logic [7:0] regRdData
);
    ////////////////////////////////////////////////////////////////////////
    // Idle port starts quiet
    initial begin
        regReq = '0;
    end

    // Released address and data are inverted so stale values never match
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regReq.wrEn = 1'b1;
        regReq.addr = a;
        regReq.wrData = d;
        @(negedge core_clk);
        regReq.wrEn = 1'b0;
        regReq.addr = ~a;
        regReq.wrData = ~d;
    endtask

    // Data is taken two falling edges after the strobe is raised
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        regReq.rdEn = 1'b1;
        regReq.addr = a;
        @(negedge core_clk);
        regReq.rdEn = 1'b0;
        regReq.addr = ~a;
        @(negedge core_clk);
        d = regRdData;
    endtask
endmodule

/* File: temp_result_filter_offset_beta_tb.sv */
/*
 * Self-checking bench for the result filter, offset and beta block.
 * Assumes the host model for register traffic; conversions, starts and
 * beta results are driven here at the falling edge of core_clk.
 */
`timescale 1ns/1ns
module temp_result_filter_offset_beta_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    trfob_pkg::trfob_reg_t regReq;
    logic [7:0] regRdData;
    logic [3:1] convStart = '0;
    trfob_pkg::trfob_conv_t conv = '0;
    trfob_pkg::trfob_beta_t beta = '0;
    logic [3:1][15:0] tempOut;
    logic [3:1][15:0] highCmpTemp;
    logic [3:1] diodeFault;
    logic [3:1] betaCompActive;
    int fail_count = 0;
    int tests_run = 0;
    int held [1:3] = '{0, 0, 0};
    int hist [1:3][$];
    logic [7:0] regM [22:29];
    logic [3:1] actM = '0;
    logic [7:0] rd;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and host
    always #5 core_clk = ~core_clk;

    trfob_core dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .regReq(regReq),
        .regRdData(regRdData), .convStart(convStart), .conv(conv), .beta(beta),
        .tempOut(tempOut), .highCmpTemp(highCmpTemp), .diodeFault(diodeFault),
        .betaCompActive(betaCompActive));

    trfob_host_model host (.core_clk(core_clk), .regReq(regReq), .regRdData(regRdData));

    ////////////////////////////////////////////////////////////////////////
    // Comparisons and verdict
    task automatic check_reg(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_temp(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_flag(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reference model updates
    task automatic set_reg(input int a, input logic [7:0] d);
        logic [7:0] rise;
        rise = d & ~regM[24];
        host.write_reg(8'(a), d);
        if (a == 22) regM[a] = d;
        else if (a <= 25) regM[a] = d & trfob_pkg::CHAN_EN_MASK;
        for (int c = 1; c <= 3; c++) begin
            if (a == 24 && rise[c]) hist[c].delete();
        end
    endtask

    // Reported value carries the offset, compare value never does
    task automatic expect_temp(input int ch);
        int off;
        off = regM[23][ch] ? (int'(regM[22]) - 'h77) * 32 : 0;
        check_temp("tempOut", 16'(held[ch] + off), tempOut[ch]);
        check_temp("highCmpTemp", 16'(held[ch]), highCmpTemp[ch]);
    endtask

    // Filtered value is the mean of what the history holds, rounded as in the core
    task automatic convert(input int ch, input int raw);
        int s;
        @(negedge core_clk);
        conv = {1'b1, 2'(ch), 16'(raw)};
        @(negedge core_clk);
        conv.valid = 1'b0;
        conv.raw = ~conv.raw;
        if (regM[24][ch]) begin
            hist[ch].push_back(raw);
            if (hist[ch].size() > 4) void'(hist[ch].pop_front());
            s = 0;
            for (int i = 0; i < hist[ch].size(); i++) s += hist[ch][i];
            // Halves and quarters floor, thirds truncate toward zero
            if (hist[ch].size() == 3) held[ch] = s / 3;
            else held[ch] = s >>> (hist[ch].size() / 2);
        end else begin
            held[ch] = raw;
        end
        repeat (2) @(negedge core_clk);
        expect_temp(ch);
    endtask

    // Compensation enable is captured at the start pulse only
    task automatic start_conv(input int ch);
        @(negedge core_clk);
        convStart[ch] = 1'b1;
        actM[ch] = regM[25][ch];
        @(negedge core_clk);
        convStart[ch] = 1'b0;
        check_flag("betaCompActive", actM[ch], betaCompActive[ch]);
    endtask

    task automatic send_beta(input int ch, input logic [3:0] code, input logic low);
        logic flt;
        flt = low & actM[ch];
        @(negedge core_clk);
        beta = {1'b1, 2'(ch), code, low};
        @(negedge core_clk);
        beta.valid = 1'b0;
        beta.code = ~code;
        regM[25 + ch] = flt ? {4'h0, trfob_pkg::BETA_FAULT_CODE} : {4'h0, code};
        held[ch] = flt ? 0 : held[ch];
        check_flag("diodeFault", flt, diodeFault[ch]);
        @(negedge core_clk);
        check_flag("diodeFault", 1'b0, diodeFault[ch]);
        expect_temp(ch);
        host.read_reg(8'(25 + ch), rd);
        check_reg("betaCode", regM[25 + ch], rd);
    endtask

    task automatic read_all();
        for (int a = 22; a <= 29; a++) begin
            host.read_reg(8'(a), rd);
            check_reg("regRdData", regM[a], rd);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (90000) @(posedge core_clk);
        fail_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        void'($urandom(32'hd137dcca));
        regM = '{8'h77, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        read_all();
        for (int p = 0; p < 2; p++) begin
            for (int a = 22; a <= 29; a++) set_reg(a, p == 0 ? 8'hff : 8'($urandom));
            read_all();
        end
        set_reg(24, 8'h00);
        set_reg(25, 8'h00);
        set_reg(23, 8'h0e);
        foreach (regM[i]) begin
            if (i == 22) rd = 8'h00;
        end
        for (int k = 0; k < 3; k++) begin
            set_reg(22, k == 0 ? 8'h00 : (k == 1 ? 8'hff : 8'($urandom)));
            for (int c = 1; c <= 3; c++) convert(c, $urandom_range(0, 'h7fff) - 'h4000);
        end
        // Frozen core must ignore a conversion
        ce = 1'b0;
        conv = {1'b1, 2'h2, 16'h1234};
        @(negedge core_clk);
        conv.valid = 1'b0;
        ce = 1'b1;
        repeat (2) @(negedge core_clk);
        expect_temp(2);
        set_reg(24, 8'h02);
        @(negedge core_clk);
        expect_temp(1);
        for (int n = 0; n < 6; n++) convert(1, $urandom_range(0, 'h7fff) - 'h4000);
        set_reg(24, 8'h00);
        convert(1, 'h0100);
        set_reg(24, 8'h02);
        convert(1, -'h0280);
        convert(1, 'h0101);
        for (int c = 0; c <= 10; c++) send_beta(2, c == 10 ? 4'hf : 4'(c), c == 9);
        set_reg(25, 8'h08);
        start_conv(3);
        set_reg(25, 8'h00);
        check_flag("betaCompActive", 1'b1, betaCompActive[3]);
        send_beta(3, 4'h5, 1'b1);
        start_conv(3);
        send_beta(3, 4'h4, 1'b1);
        complete_run();
    end
endmodule
